// *** pkg/bsp_defines.svh ***
// constants for the buffered serial port
`ifndef BSP_DEFINES_SVH
`define BSP_DEFINES_SVH
`define BSP_CLK_HZ       10000000
`define BSP_BAUD_DEF     9600
`define BSP_DIV_DEF      (`BSP_CLK_HZ / `BSP_BAUD_DEF)
`define BSP_DIV_W        16
`define BSP_DEPTH        256
`define BSP_PTR_W        8
`define BSP_CNT_W        9
`define BSP_CAP_LIMIT    9'h080
`define BSP_XON          8'h11
`define BSP_XOFF         8'h13
`define BSP_ASCII_MAX    8'h7f
`define BSP_DATA_BITS    4'h8
`endif

// *** pkg/bsp_pkg.sv ***
// types for the buffered serial port
package bsp_pkg;
    typedef enum logic [1:0] {BSP_RD_SINGLE, BSP_RD_LINE, BSP_RD_CAPTURE} bsp_mode_t;
    typedef enum {BSP_TX_IDLE, BSP_TX_START, BSP_TX_DATA, BSP_TX_STOP} bsp_txst_t;
    typedef enum {BSP_RX_IDLE, BSP_RX_START, BSP_RX_DATA, BSP_RX_STOP} bsp_rxst_t;
    // a character with its valid flag
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } bsp_char_t;
endpackage

// *** rtl/bsp_fifo.sv ***
// 256-entry character buffer with occupancy count
`timescale 1ns/10ps
`include "bsp_defines.svh"
module bsp_fifo
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    // write side
    input  wire logic                  wr,
    input  wire logic [7:0]            wdata,
    // read side
    input  wire logic                  rd,
    output logic      [7:0]            rdata,
    output logic      [`BSP_CNT_W-1:0] count
);
    typedef struct packed {
        logic [`BSP_PTR_W-1:0] wp;
        logic [`BSP_PTR_W-1:0] rp;
        logic [`BSP_CNT_W-1:0] cnt;
    } bsp_fst_t;

    bsp_fst_t   st_ff;
    bsp_fst_t   nxt_st;
    logic [7:0] mem [0:`BSP_DEPTH-1];
    logic       do_wr;
    logic       do_rd;

    // a write into a full buffer is refused, contents kept
    assign do_wr = wr && (st_ff.cnt != `BSP_CNT_W'(`BSP_DEPTH));
    assign do_rd = rd && (st_ff.cnt != '0);
    assign rdata = mem[st_ff.rp];
    assign count = st_ff.cnt;

    // pointer and count update
    always_comb
    begin
        nxt_st = st_ff;
        if (do_wr)
            nxt_st.wp = st_ff.wp + 8'h01;
        if (do_rd)
            nxt_st.rp = st_ff.rp + 8'h01;
        if (do_wr && !do_rd)
            nxt_st.cnt = st_ff.cnt + 9'h001;
        else if (do_rd && !do_wr)
            nxt_st.cnt = st_ff.cnt - 9'h001;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    // storage has no reset, only written slots are ever read
    always_ff @(posedge clk)
    begin
        if (do_wr)
            mem[st_ff.wp] <= wdata;
    end
endmodule // bsp_fifo

// *** rtl/bsp_serial_port.sv ***
// buffered serial port: transmitter, receiver, flow control and read modes
`timescale 1ns/10ps
`include "bsp_defines.svh"
module bsp_serial_port
(
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    // configuration
    input  wire logic [`BSP_DIV_W-1:0]   baud_div,
    input  wire logic                    baud_load,
    input  wire logic                    sel_diff,
    input  wire logic                    console_mode,
    input  wire bsp_pkg::bsp_mode_t      rd_mode,
    input  wire logic [7:0]              term_char,
    // transmit producer
    input  wire bsp_pkg::bsp_char_t      tx_in,
    output logic                         tx_ready,
    // consumer
    input  wire logic                    rd_req,
    output bsp_pkg::bsp_char_t           rd_out,
    output logic                         rd_empty,
    output logic                         line_ready,
    output logic                         cap_event,
    output logic                         rx_event,
    // serial pins
    input  wire logic                    rxd_primary,
    input  wire logic                    rxd_diff,
    input  wire logic                    rts,
    output logic                         txd_primary,
    output logic                         txd_diff
);
    typedef struct packed {
        logic [`BSP_DIV_W-1:0] div;
        bsp_pkg::bsp_txst_t    tst;
        logic [`BSP_DIV_W-1:0] tcnt;
        logic [3:0]            tbit;
        logic [7:0]            tsh;
        logic                  txd;
        bsp_pkg::bsp_rxst_t    rst;
        logic [`BSP_DIV_W-1:0] rcnt;
        logic [3:0]            rbit;
        logic [7:0]            rsh;
        logic                  paused;
        logic                  send_xoff;
        logic                  send_xon;
        logic                  xoff_sent;
        logic [`BSP_CNT_W-1:0] term_cnt;
        logic [`BSP_CNT_W-1:0] drain;
        logic                  tx_ready;
        bsp_pkg::bsp_char_t    rd_out;
        logic                  rd_empty;
        logic                  line_ready;
        logic                  cap_event;
        logic                  rx_event;
        logic                  txd_p;
        logic                  txd_d;
    } bsp_st_t;

    bsp_st_t               st_ff;
    bsp_st_t               nxt_st;
    logic [7:0]            txf_data;
    logic [`BSP_CNT_W-1:0] txf_cnt;
    logic [7:0]            rxf_data;
    logic [`BSP_CNT_W-1:0] rxf_cnt;
    logic                  txf_rd;
    logic                  rxf_wr;
    logic                  rxf_rd;
    logic                  rxd;

    // static choice of physical channel
    assign rxd = sel_diff ? rxd_diff : rxd_primary;

    // line extraction on the console takes 7-bit characters only
    function automatic logic char_ok(input logic [7:0] c, input logic cons, input logic ln);
        char_ok = !(cons && ln) || (c <= `BSP_ASCII_MAX);
    endfunction

    function automatic logic is_pacing(input logic [7:0] c);
        is_pacing = (c == `BSP_XON) || (c == `BSP_XOFF);
    endfunction

    bsp_fifo u_txf
    (
        .clk     (clk),
        .reset_n (reset_n),
        .wr      (tx_in.valid && st_ff.tx_ready),
        .wdata   (tx_in.data),
        .rd      (txf_rd),
        .rdata   (txf_data),
        .count   (txf_cnt)
    );

    bsp_fifo u_rxf
    (
        .clk     (clk),
        .reset_n (reset_n),
        .wr      (rxf_wr),
        .wdata   (st_ff.rsh),
        .rd      (rxf_rd),
        .rdata   (rxf_data),
        .count   (rxf_cnt)
    );

    // whole next state: baud, tx and rx engines, pacing and read modes
    always_comb
    begin
        logic tx_go;
        logic rx_done;
        logic take;
        tx_go   = 1'b0;
        rx_done = 1'b0;
        take    = 1'b0;
        nxt_st  = st_ff;
        txf_rd  = 1'b0;
        rxf_wr  = 1'b0;
        rxf_rd  = 1'b0;
        nxt_st.rx_event  = 1'b0;
        nxt_st.cap_event = 1'b0;
        nxt_st.rd_out    = '0;
        if (baud_load)
            nxt_st.div = baud_div;
        // transmitter; rts low holds off only between characters
        case (st_ff.tst)
            bsp_pkg::BSP_TX_IDLE:
            begin
                nxt_st.txd = 1'b1;
                if (rts)
                begin
                    if (st_ff.send_xoff || st_ff.send_xon)
                    begin
                        nxt_st.tsh       = st_ff.send_xoff ? `BSP_XOFF : `BSP_XON;
                        nxt_st.xoff_sent = st_ff.send_xoff;
                        nxt_st.send_xoff = 1'b0;
                        nxt_st.send_xon  = 1'b0;
                        tx_go            = 1'b1;
                    end
                    else if (!st_ff.paused && txf_cnt != '0)
                    begin
                        nxt_st.tsh = txf_data;
                        txf_rd     = 1'b1;
                        tx_go      = 1'b1;
                    end
                end
                if (tx_go)
                begin
                    nxt_st.tst  = bsp_pkg::BSP_TX_START;
                    nxt_st.tcnt = st_ff.div;
                    nxt_st.txd  = 1'b0;
                end
            end
            default:
            begin
                nxt_st.tcnt = st_ff.tcnt - 16'h0001;
                if (st_ff.tcnt == 16'h0001)
                begin
                    nxt_st.tcnt = st_ff.div;
                    case (st_ff.tst)
                        bsp_pkg::BSP_TX_START:
                        begin
                            nxt_st.tst  = bsp_pkg::BSP_TX_DATA;
                            nxt_st.tbit = '0;
                            nxt_st.txd  = st_ff.tsh[0];
                        end
                        bsp_pkg::BSP_TX_DATA:
                        begin
                            nxt_st.tsh  = {1'b0, st_ff.tsh[7:1]};
                            nxt_st.tbit = st_ff.tbit + 4'h1;
                            nxt_st.txd  = st_ff.tsh[1];
                            if (st_ff.tbit == `BSP_DATA_BITS - 4'h1)
                            begin
                                nxt_st.tst = bsp_pkg::BSP_TX_STOP;
                                nxt_st.txd = 1'b1;
                            end
                        end
                        default:
                            nxt_st.tst = bsp_pkg::BSP_TX_IDLE;
                    endcase
                end
            end
        endcase
        // receiver samples mid-bit, one stop bit, no parity
        case (st_ff.rst)
            bsp_pkg::BSP_RX_IDLE:
            begin
                if (!rxd)
                begin
                    nxt_st.rst  = bsp_pkg::BSP_RX_START;
                    nxt_st.rcnt = {1'b0, st_ff.div[`BSP_DIV_W-1:1]};
                end
            end
            default:
            begin
                nxt_st.rcnt = st_ff.rcnt - 16'h0001;
                if (st_ff.rcnt <= 16'h0001)
                begin
                    nxt_st.rcnt = st_ff.div;
                    case (st_ff.rst)
                        bsp_pkg::BSP_RX_START:
                        begin
                            nxt_st.rst  = rxd ? bsp_pkg::BSP_RX_IDLE : bsp_pkg::BSP_RX_DATA;
                            nxt_st.rbit = '0;
                        end
                        bsp_pkg::BSP_RX_DATA:
                        begin
                            nxt_st.rsh  = {rxd, st_ff.rsh[7:1]};
                            nxt_st.rbit = st_ff.rbit + 4'h1;
                            if (st_ff.rbit == `BSP_DATA_BITS - 4'h1)
                                nxt_st.rst = bsp_pkg::BSP_RX_STOP;
                        end
                        default:
                        begin
                            nxt_st.rst = bsp_pkg::BSP_RX_IDLE;
                            rx_done    = rxd;
                        end
                    endcase
                end
            end
        endcase
        // received pacing characters steer the transmitter, others are stored if char_ok accepts them
        if (rx_done)
        begin
            nxt_st.rx_event = 1'b1;
            if (is_pacing(st_ff.rsh))
                nxt_st.paused = (st_ff.rsh == `BSP_XOFF);
            else if (char_ok(st_ff.rsh, console_mode, rd_mode == bsp_pkg::BSP_RD_LINE))
            begin
                rxf_wr = 1'b1;
                if (st_ff.rsh == term_char && rxf_cnt != 9'h100)
                    nxt_st.term_cnt = st_ff.term_cnt + 9'h001;
            end
        end
        // ask the far side to pause near full and resume once half drained
        if (rxf_cnt >= 9'h0f0 && !st_ff.xoff_sent && !st_ff.send_xoff)
            nxt_st.send_xoff = 1'b1;
        if (rxf_cnt < 9'h080 && st_ff.xoff_sent && !st_ff.send_xon)
        begin
            nxt_st.send_xon  = 1'b1;
            nxt_st.xoff_sent = 1'b0;
        end
        // read modes
        if (st_ff.drain != '0 && rxf_cnt != '0)
        begin
            take          = 1'b1;
            nxt_st.drain  = st_ff.drain - 9'h001;
        end
        else if (st_ff.drain == '0 && rd_req && rxf_cnt != '0)
        begin
            case (rd_mode)
                bsp_pkg::BSP_RD_SINGLE:
                    take = 1'b1;
                bsp_pkg::BSP_RD_LINE:
                    if (st_ff.term_cnt != '0)
                    begin
                        take         = 1'b1;
                        nxt_st.drain = 9'h1ff; // runs until the terminator leaves
                    end
                default:
                    if (st_ff.line_ready)
                    begin
                        take         = 1'b1;
                        nxt_st.drain = rxf_cnt - 9'h001;
                    end
            endcase
        end
        if (take)
        begin
            rxf_rd        = 1'b1;
            nxt_st.rd_out = '{valid: 1'b1, data: rxf_data};
            if (rxf_data == term_char && st_ff.term_cnt != '0)
            begin
                nxt_st.term_cnt = nxt_st.term_cnt - 9'h001;
                if (rd_mode == bsp_pkg::BSP_RD_LINE)
                    nxt_st.drain = '0;
            end
        end
        // readiness flags; capture fires on terminator or 128 characters
        nxt_st.rd_empty = (rxf_cnt == '0) && !rxf_wr || (rxf_cnt == 9'h001 && rxf_rd && !rxf_wr);
        if (rd_mode == bsp_pkg::BSP_RD_CAPTURE)
        begin
            nxt_st.line_ready = (nxt_st.term_cnt != '0) || (rxf_cnt >= `BSP_CAP_LIMIT);
            nxt_st.cap_event  = nxt_st.line_ready && !st_ff.line_ready;
        end
        else
            nxt_st.line_ready = nxt_st.term_cnt != '0;
        // producer stalls only with a full buffer; margin covers the write in flight
        nxt_st.tx_ready = txf_cnt < 9'h0ff || (txf_cnt == 9'h0ff && !(tx_in.valid && st_ff.tx_ready));
        nxt_st.txd_p = sel_diff ? 1'b1 : nxt_st.txd;
        nxt_st.txd_d = sel_diff ? nxt_st.txd : 1'b1;
    end

    // single register stage; reset loads the 9600 8N1 divisor
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_ff          <= '0;
            st_ff.div      <= `BSP_DIV_W'(`BSP_DIV_DEF);
            st_ff.txd      <= 1'b1;
            st_ff.txd_p    <= 1'b1;
            st_ff.txd_d    <= 1'b1;
            st_ff.rd_empty <= 1'b1;
            st_ff.tst      <= bsp_pkg::BSP_TX_IDLE;
            st_ff.rst      <= bsp_pkg::BSP_RX_IDLE;
        end
        else
            st_ff <= nxt_st;
    end

    assign tx_ready    = st_ff.tx_ready;
    assign rd_out      = st_ff.rd_out;
    assign rd_empty    = st_ff.rd_empty;
    assign line_ready  = st_ff.line_ready;
    assign cap_event   = st_ff.cap_event;
    assign rx_event    = st_ff.rx_event;
    assign txd_primary = st_ff.txd_p;
    assign txd_diff    = st_ff.txd_d;
endmodule // bsp_serial_port

// *** sim/bsp_serial_port_assertions.sv ***
// port-level checks for the buffered serial port
`timescale 1ns/10ps
module bsp_serial_port_assertions
(
    // clock and reset
    input wire logic               clk,
    input wire logic               reset_n,
    // inputs
    input wire logic               sel_diff,
    input wire bsp_pkg::bsp_mode_t rd_mode,
    input wire logic               rd_req,
    input wire logic               rts,
    // outputs
    input wire bsp_pkg::bsp_char_t rd_out,
    input wire logic               cap_event,
    input wire logic               rx_event,
    input wire logic               txd_primary,
    input wire logic               txd_diff
);
    // cycles of rts held low, saturating so it never wraps to zero
    logic [7:0] rts_lo_ff;
    logic [7:0] nxt_rts_lo;
    always_comb
    begin
        nxt_rts_lo = rts ? 8'h00 : rts_lo_ff + {7'h00, rts_lo_ff != 8'hff};
    end
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rts_lo_ff <= 8'h00;
        else
            rts_lo_ff <= nxt_rts_lo;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // a bit lasts at least four clocks at the smallest divisor used
    sequence s_bit_low;
        !txd_primary [*4];
    endsequence
    sequence s_no_frame;
        !rx_event [*8];
    endsequence
    property p_start_width;
        ($fell(txd_primary) && !sel_diff) |-> s_bit_low;
    endproperty
    a_start_width: assert property (p_start_width) else $error("start bit too short");
    // a line or capture drain started by one request keeps delivering on its own
    property p_rd_cause;
        rd_out.valid |-> $past(rd_req) || $past(rd_out.valid);
    endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("read data without request");
    property p_cap_mode;
        cap_event |-> rd_mode == bsp_pkg::BSP_RD_CAPTURE;
    endproperty
    a_cap_mode: assert property (p_cap_mode) else $error("capture event outside capture");
    property p_cap_pulse;
        cap_event |=> !cap_event;
    endproperty
    a_cap_pulse: assert property (p_cap_pulse) else $error("capture event too long");
    property p_rx_pulse;
        rx_event |=> s_no_frame;
    endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("receive event repeated");
    // fifty clocks let any frame in flight finish at divisor four
    property p_rts_hold;
        rts_lo_ff >= 8'h32 |-> txd_primary && txd_diff;
    endproperty
    a_rts_hold: assert property (p_rts_hold) else $error("sent while held off");
    property p_pri_idle;
        sel_diff |-> txd_primary;
    endproperty
    a_pri_idle: assert property (p_pri_idle) else $error("primary active");
    property p_diff_idle;
        !sel_diff |-> txd_diff;
    endproperty
    a_diff_idle: assert property (p_diff_idle) else $error("differential active");
endmodule // bsp_serial_port_assertions

bind bsp_serial_port bsp_serial_port_assertions bsp_serial_port_assertions_inst (.clk(clk),
    .reset_n(reset_n), .sel_diff(sel_diff), .rd_mode(rd_mode), .rd_req(rd_req), .rts(rts),
    .rd_out(rd_out), .cap_event(cap_event), .rx_event(rx_event), .txd_primary(txd_primary),
    .txd_diff(txd_diff));

// *** sim/bsp_term_model.sv ***
// serial terminal model on the far side of the port
`timescale 1ns/10ps
module bsp_term_model
#(
    parameter int BIT_CLKS = 4
)
(
    // clock
    input  wire logic clk,
    // serial lines
    input  wire logic txd,
    output logic      rxd,
    output logic      rts
);
    logic [7:0] got_q[$];
    logic [7:0] sh;
    logic       rts_v = 1'b1;
    logic       paused = 1'b0;
    logic       ignore_pace = 1'b0; // set only to force an overflow
    int         xoff_n = 0;
    int         xon_n = 0;
    assign rts = rts_v;
    initial rxd = 1'b1;
    // decoder samples mid-bit so a one-clock skew is harmless
    always
    begin
        @(posedge clk);
        if (txd === 1'b0)
        begin
            repeat (BIT_CLKS / 2) @(posedge clk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT_CLKS) @(posedge clk);
                sh[i] = txd;
            end
            repeat (BIT_CLKS) @(posedge clk);
            if (sh == 8'h13)
            begin
                paused = 1'b1;
                xoff_n++;
            end
            else if (sh == 8'h11)
            begin
                paused = 1'b0;
                xon_n++;
            end
            else
                got_q.push_back(sh);
        end
    end
    // one 8N1 frame, lsb first, holding off while paused
    task automatic send(input logic [7:0] b);
        while (paused && !ignore_pace) @(negedge clk);
        @(negedge clk);
        rxd = 1'b0;
        repeat (BIT_CLKS) @(negedge clk);
        for (int i = 0; i < 8; i++)
        begin
            rxd = b[i];
            repeat (BIT_CLKS) @(negedge clk);
        end
        rxd = 1'b1;
        repeat (BIT_CLKS) @(negedge clk);
    endtask
endmodule // bsp_term_model

// *** sim/bsp_serial_port_tb.sv ***
// self-checking bench for the buffered serial port
`timescale 1ns/10ps
`include "bsp_defines.svh"
module bsp_serial_port_tb;
    logic                  clk;
    logic                  reset_n = 1'b0;
    logic [`BSP_DIV_W-1:0] baud_div = 16'h0000;
    logic                  baud_load = 1'b0;
    logic                  sel_diff = 1'b0;
    logic                  console_mode = 1'b0;
    bsp_pkg::bsp_mode_t    rd_mode = bsp_pkg::BSP_RD_SINGLE;
    logic [7:0]            term_char = 8'h0d;
    bsp_pkg::bsp_char_t    tx_in = '0;
    logic                  tx_ready, rd_req = 1'b0, rd_empty, line_ready, cap_event, rx_event;
    bsp_pkg::bsp_char_t    rd_out;
    logic                  rxd, rts, txd_primary, txd_diff;
    logic [7:0]            got[$];
    int                    num_errors = 0, num_checks = 0, rx_n = 0, cap_n = 0, cyc = 0;
    int                    n, k, a, b;
    bsp_serial_port bsp_serial_port_inst (.clk(clk), .reset_n(reset_n), .baud_div(baud_div),
        .baud_load(baud_load), .sel_diff(sel_diff), .console_mode(console_mode),
        .rd_mode(rd_mode), .term_char(term_char), .tx_in(tx_in), .tx_ready(tx_ready),
        .rd_req(rd_req), .rd_out(rd_out), .rd_empty(rd_empty), .line_ready(line_ready),
        .cap_event(cap_event), .rx_event(rx_event), .rxd_primary(rxd), .rxd_diff(rxd),
        .rts(rts), .txd_primary(txd_primary), .txd_diff(txd_diff));
    bsp_term_model bsp_term_model_inst (.clk(clk), .txd(txd_primary), .rxd(rxd), .rts(rts));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // event counters and the hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (rx_event === 1'b1) rx_n++;
        if (cap_event === 1'b1) cap_n++;
        if (cyc == 90000)
        begin
            num_errors++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // holds rd_req for r cycles and gathers delivered characters for r+m cycles
    task automatic collect(input int r, input int m);
        got.delete();
        for (int i = 0; i < r + m; i++)
        begin
            @(negedge clk);
            rd_req = (i < r);
            if (rd_out.valid === 1'b1) got.push_back(rd_out.data);
        end
    endtask
    task automatic put(input logic [7:0] d);
        @(negedge clk);
        tx_in = {1'b1, d};
        while (tx_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        tx_in = '0;
    endtask
    task automatic wait_tx(input int cnt, input int lim);
        for (int i = 0; i < lim && bsp_term_model_inst.got_q.size() < cnt; i++) @(negedge clk);
    endtask
    // low cycles on each line over one window after a write of 8'h01
    task automatic low_time(output int p, output int d);
        p = 0;
        d = 0;
        put(8'h01);
        repeat (1100)
        begin
            @(negedge clk);
            p += !txd_primary;
            d += !txd_diff;
        end
    endtask
    task automatic t_reset();
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        chk("tx_ready", 16'h1, tx_ready);
        chk("rd_empty", 16'h1, rd_empty);
    endtask
    task automatic t_tx();
        low_time(a, b);
        chk("default bit", `BSP_DIV_DEF, a);
        repeat (9500) @(negedge clk);
        bsp_term_model_inst.got_q.delete();
        baud_div = 16'h0004;
        baud_load = 1'b1;
        @(negedge clk);
        baud_load = 1'b0;
        put(8'h00);
        put(8'hff);
        put(8'h80);
        put(8'h5a);
        wait_tx(4, 400);
        chk("tx 0", 16'h00, bsp_term_model_inst.got_q[0]);
        chk("tx 1", 16'hff, bsp_term_model_inst.got_q[1]);
        chk("tx 2", 16'h80, bsp_term_model_inst.got_q[2]);
        chk("tx 3", 16'h5a, bsp_term_model_inst.got_q[3]);
        bsp_term_model_inst.send(8'h13);
        put(8'h3c);
        repeat (100) @(negedge clk);
        chk("paused", 16'd4, bsp_term_model_inst.got_q.size());
        bsp_term_model_inst.send(8'h11);
        wait_tx(5, 200);
        chk("resumed", 16'h3c, bsp_term_model_inst.got_q[4]);
        chk("pace kept", 16'h1, rd_empty);
    endtask
    task automatic t_tx_full();
        bsp_term_model_inst.rts_v = 1'b0;
        repeat (60) @(negedge clk);
        tx_in = {1'b1, 8'h55};
        n = 0;
        k = 0;
        while (k < 20)
        begin
            if (tx_ready === 1'b1) n++;
            k = (tx_ready === 1'b1) ? 0 : k + 1;
            @(negedge clk);
        end
        tx_in = '0;
        chk("fill", 16'h1, n >= 256 && n <= 257);
        chk("held", 16'd5, bsp_term_model_inst.got_q.size());
        bsp_term_model_inst.rts_v = 1'b1;
        wait_tx(5 + n, 12000);
        chk("drained", 16'(5 + n), bsp_term_model_inst.got_q.size());
    endtask
    task automatic t_rx();
        a = rx_n;
        bsp_term_model_inst.send(8'hc5);
        bsp_term_model_inst.send(8'h00);
        repeat (4) @(negedge clk);
        chk("rx events", 16'd2, 16'(rx_n - a));
        collect(4, 4);
        chk("single n", 16'd2, got.size());
        chk("single 0", 16'hc5, got[0]);
        chk("empty", 16'h1, rd_empty);
        a = rx_n;
        b = bsp_term_model_inst.xoff_n;
        bsp_term_model_inst.ignore_pace = 1'b1;
        for (int i = 0; i < 257; i++) bsp_term_model_inst.send(i < 256 ? 8'h41 : 8'h5a);
        repeat (4) @(negedge clk);
        chk("rx events", 16'd257, 16'(rx_n - a));
        chk("xoff", 16'd1, 16'(bsp_term_model_inst.xoff_n - b));
        a = bsp_term_model_inst.xon_n;
        collect(260, 4);
        bsp_term_model_inst.ignore_pace = 1'b0;
        chk("kept", 16'd256, got.size());
        chk("last", 16'h41, got[255]);
        repeat (100) @(negedge clk);
        chk("xon", 16'd1, 16'(bsp_term_model_inst.xon_n - a));
    endtask
    task automatic t_modes();
        console_mode = 1'b1;
        rd_mode = bsp_pkg::BSP_RD_LINE;
        bsp_term_model_inst.send(8'h41);
        bsp_term_model_inst.send(8'hc1);
        bsp_term_model_inst.send(8'h42);
        collect(6, 4);
        chk("line wait", 16'd0, got.size());
        bsp_term_model_inst.send(8'h0d);
        collect(8, 4);
        chk("line n", 16'd3, got.size());
        chk("line end", 16'h0d, got[2]);
        console_mode = 1'b0;
        rd_mode = bsp_pkg::BSP_RD_CAPTURE;
        term_char = 8'h2e;
        a = cap_n;
        bsp_term_model_inst.send(8'hf0);
        bsp_term_model_inst.send(8'h61);
        bsp_term_model_inst.send(8'h2e);
        repeat (6) @(negedge clk);
        chk("cap term", 16'd1, 16'(cap_n - a));
        collect(1, 140);
        chk("cap n", 16'd3, got.size());
        chk("cap 0", 16'hf0, got[0]);
        repeat (128) bsp_term_model_inst.send(8'h62);
        repeat (6) @(negedge clk);
        chk("cap full", 16'd2, 16'(cap_n - a));
        collect(1, 140);
        chk("cap 128", 16'd128, got.size());
    endtask
    task automatic t_diff();
        reset_n = 1'b0;
        sel_diff = 1'b1;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        low_time(a, b);
        chk("pri low", 16'd0, 16'(a));
        chk("diff bit", `BSP_DIV_DEF, 16'(b));
        // reception with sel_diff set, rxd_primary and rxd_diff driven from the same line
        rd_mode = bsp_pkg::BSP_RD_SINGLE;
        baud_load = 1'b1;
        @(negedge clk);
        baud_load = 1'b0;
        bsp_term_model_inst.send(8'ha7);
        collect(1, 4);
        chk("diff rx", 16'ha7, got[0]);
    endtask
    initial
    begin
        t_reset();
        t_tx();
        t_tx_full();
        t_rx();
        t_modes();
        t_diff();
        close_out();
    end
endmodule // bsp_serial_port_tb
